// [hw/ddrcap_pkg.sv]
// Package: constants, modes and carriers of the input capture block
`default_nettype none
package ddrcap_pkg;

  localparam int DDRCAP_AW = 8;
  localparam int DDRCAP_DW = 32;
  localparam int DDRCAP_DELAY_TAPS = 16;
  localparam int DDRCAP_CODE_W = 4;
  localparam int DDRCAP_SYNC_W = 5;

  localparam logic [DDRCAP_AW-1:0] DDRCAP_CFG_OFS = 8'h00;
  localparam logic [DDRCAP_AW-1:0] DDRCAP_STATUS_OFS = 8'h04;

  localparam int DDRCAP_CFG_W = 6;
  localparam logic [DDRCAP_CFG_W-1:0] DDRCAP_CFG_RESET = 6'h00;
  localparam int DDRCAP_STATUS_W = 10;

  // Sync vector bit positions
  localparam int DDRCAP_SI_STROBE = 0;
  localparam int DDRCAP_SI_EDGE_CLOCK = 1;
  localparam int DDRCAP_SI_PAD = 2;
  localparam int DDRCAP_SI_POL = 3;
  localparam int DDRCAP_SI_LAT = 4;

  typedef enum logic [1:0] {
    DDRCAP_SDR = 2'h0,
    DDRCAP_DDR_MEM = 2'h1,
    DDRCAP_DDR_GEN = 2'h2,
    DDRCAP_SPARE = 2'h3
  } ddrcap_mode_t;

  typedef struct packed {
    logic strobe_feed;
    logic gear_en;
    logic dyn_delay;
    logic delay_en;
    ddrcap_mode_t mode;
  } ddrcap_cfg_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } ddrcap_pair_t;

  typedef struct packed {
    logic neg_a;
    logic pos_a;
    logic neg_b;
    logic pos_b;
  } ddrcap_gear_t;

endpackage
`default_nettype wire

// [hw/ddrcap_sync.sv]
// Three-stage synchroniser with agreement filter and edge pulses
`default_nettype none
module ddrcap_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg, fall_reg;
      logic lvl_next, rise_next, fall_next;

      // Change accepted only when stages two and three agree
      always_comb begin
        lvl_next = lvl_reg;
        if (s2_reg == s3_reg) begin
          lvl_next = s3_reg;
        end
        rise_next = lvl_next & ~lvl_reg;
        fall_next = ~lvl_next & lvl_reg;
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
          rise_reg <= 1'b0;
          fall_reg <= 1'b0;
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          lvl_reg <= lvl_next;
          rise_reg <= rise_next;
          fall_reg <= fall_next;
        end
      end

      assign level_out[i] = lvl_reg;
      assign rise_out[i] = rise_reg;
      assign fall_out[i] = fall_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// [hw/ddrcap_input_block.sv]
// Per-pin input capture block: bypass, delay, SDR, DDR and gearbox paths
`default_nettype none
module ddrcap_input_block
  import ddrcap_pkg::*;
#(
  parameter int DELAY_TAPS = DDRCAP_DELAY_TAPS,
  parameter int FIXED_DELAY_TAP = 8,
  parameter bit GEARBOX_SIDE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pad_input_data,
  input wire logic read_strobe_edge_clock,
  input wire logic edge_clock,
  input wire logic sync_clock_polarity,
  input wire logic sync_transfer_latch,
  input wire logic [DDRCAP_CODE_W-1:0] dynamic_delay_code,
  input wire logic [DDRCAP_AW-1:0] reg_addr,
  input wire logic [DDRCAP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic bypass_comb_input,
  output logic bypass_clock_input,
  output logic strobe_delay_feed,
  output logic sdr_data_out,
  output ddrcap_pair_t ddr_data_out,
  output logic gear_neg_stream_a,
  output logic gear_pos_stream_a,
  output logic gear_neg_stream_b,
  output logic gear_pos_stream_b,
  output logic [DDRCAP_DW-1:0] reg_rdata
);

  // Bypass around registers and delay
  assign bypass_comb_input = pad_input_data;
  assign bypass_clock_input = pad_input_data;

  // Synchronised pins and link clocks
  logic [DDRCAP_SYNC_W-1:0] sync_in, sync_lvl, sync_rise, sync_fall;

  // Strobe, polarity and latch are inputs, never generated here
  assign sync_in = {sync_transfer_latch, sync_clock_polarity, pad_input_data,
                    edge_clock, read_strobe_edge_clock};

  ddrcap_sync #(
    .W(DDRCAP_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(sync_in),
    .level_out(sync_lvl),
    .rise_out(sync_rise),
    .fall_out(sync_fall)
  );

  logic pad_s, pol_s, lat_s, edge_clock_rise;
  assign pad_s = sync_lvl[DDRCAP_SI_PAD];
  // Polarity follows the read control each read cycle
  assign pol_s = sync_lvl[DDRCAP_SI_POL];
  assign lat_s = sync_lvl[DDRCAP_SI_LAT];
  assign edge_clock_rise = sync_rise[DDRCAP_SI_EDGE_CLOCK];

  // Configuration register
  ddrcap_cfg_t cfg_reg, cfg_next;
  logic [DDRCAP_DW-1:0] rdata_reg, rdata_next;
  logic [DDRCAP_STATUS_W-1:0] status_w;

  assign strobe_delay_feed = cfg_reg.strobe_feed & pad_input_data;

  // Delay line
  logic [DELAY_TAPS-1:0] dly_reg, dly_next;
  logic din;

  always_comb begin
    dly_next = {dly_reg[DELAY_TAPS-2:0], pad_s};
    din = pad_s;
    if (cfg_reg.delay_en) begin
      if (cfg_reg.dyn_delay) begin
        din = dly_reg[dynamic_delay_code];
      end else begin
        din = dly_reg[FIXED_DELAY_TAP];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dly_reg <= '0;
    end else begin
      dly_reg <= dly_next;
    end
  end

  // Capture registers
  logic sdr_reg, sdr_next;
  ddrcap_pair_t cap_reg, cap_next;
  logic cap_rise, cap_fall;

  always_comb begin
    cap_rise = 1'b0;
    cap_fall = 1'b0;
    unique case (cfg_reg.mode)
      DDRCAP_DDR_MEM: begin
        cap_rise = sync_rise[DDRCAP_SI_STROBE];
        cap_fall = sync_fall[DDRCAP_SI_STROBE];
      end
      DDRCAP_DDR_GEN: begin
        cap_rise = sync_rise[DDRCAP_SI_EDGE_CLOCK];
        cap_fall = sync_fall[DDRCAP_SI_EDGE_CLOCK];
      end
      default: begin
        cap_rise = 1'b0;
        cap_fall = 1'b0;
      end
    endcase
  end

  always_comb begin
    sdr_next = sdr_reg;
    cap_next = cap_reg;
    if (cfg_reg.mode == DDRCAP_SDR) begin
      sdr_next = din;
    end
    if (cap_rise) begin
      cap_next.pos = din;
    end
    if (cap_fall) begin
      cap_next.neg = din;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdr_reg <= 1'b0;
      cap_reg <= '0;
    end else begin
      sdr_reg <= sdr_next;
      cap_reg <= cap_next;
    end
  end

  assign sdr_data_out = sdr_reg;

  // Gearbox edge-clock stage
  logic gear_act;
  logic phase_reg, phase_next;
  ddrcap_pair_t ga_reg, ga_next, gb_reg, gb_next;

  assign gear_act = GEARBOX_SIDE & cfg_reg.gear_en &
                    (cfg_reg.mode != DDRCAP_SDR);

  always_comb begin
    phase_next = phase_reg;
    ga_next = ga_reg;
    gb_next = gb_reg;
    if (!gear_act) begin
      phase_next = 1'b0;
    end else if (edge_clock_rise) begin
      phase_next = ~phase_reg;
      // First pair then second pair, on edge clock
      if (!phase_reg) begin
        ga_next = cap_reg;
      end else begin
        gb_next = cap_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= 1'b0;
      ga_reg <= '0;
      gb_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      ga_reg <= ga_next;
      gb_reg <= gb_next;
    end
  end

  // System clock synchronisation under polarity select
  ddrcap_pair_t se_reg, se_next, sl_reg, sl_next, ssel;
  ddrcap_gear_t ge_reg, ge_next, gl_reg, gl_next, gsel;

  always_comb begin
    se_next = cap_reg;
    sl_next = se_reg;
    ge_next = '{neg_a: ga_reg.neg, pos_a: ga_reg.pos,
                neg_b: gb_reg.neg, pos_b: gb_reg.pos};
    gl_next = ge_reg;
    // Late edge adds one system clock cycle of delay
    ssel = pol_s ? sl_reg : se_reg;
    gsel = pol_s ? gl_reg : ge_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      se_reg <= '0;
      sl_reg <= '0;
      ge_reg <= '0;
      gl_reg <= '0;
    end else begin
      se_reg <= se_next;
      sl_reg <= sl_next;
      ge_reg <= ge_next;
      gl_reg <= gl_next;
    end
  end

  // Transfer and gearbox output registers
  ddrcap_pair_t xfer_reg, xfer_next;
  ddrcap_gear_t gout_reg, gout_next;

  always_comb begin
    xfer_next = xfer_reg;
    gout_next = gout_reg;
    if (lat_s) begin
      xfer_next = ssel;
      if (gear_act) begin
        gout_next = gsel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_reg <= '0;
      gout_reg <= '0;
    end else begin
      xfer_reg <= xfer_next;
      gout_reg <= gout_next;
    end
  end

  assign ddr_data_out = xfer_reg;
  assign gear_neg_stream_a = gout_reg.neg_a;
  assign gear_pos_stream_a = gout_reg.pos_a;
  assign gear_neg_stream_b = gout_reg.neg_b;
  assign gear_pos_stream_b = gout_reg.pos_b;

  // Register port
  assign status_w = {gear_act, phase_reg, pol_s, lat_s, gout_reg, xfer_reg};

  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = '0;
    if (reg_wr && reg_addr == DDRCAP_CFG_OFS) begin
      cfg_next = ddrcap_cfg_t'(reg_wdata[DDRCAP_CFG_W-1:0]);
    end
    if (reg_rd) begin
      unique case (reg_addr)
        DDRCAP_CFG_OFS: begin
          rdata_next = {{(DDRCAP_DW-DDRCAP_CFG_W){1'b0}}, cfg_reg};
        end
        DDRCAP_STATUS_OFS: begin
          rdata_next = {{(DDRCAP_DW-DDRCAP_STATUS_W){1'b0}}, status_w};
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= ddrcap_cfg_t'(DDRCAP_CFG_RESET);
      rdata_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule
`default_nettype wire

// [tb/ddrcap_properties.sv]
// Port checker of the input capture block
`default_nettype none
module ddrcap_properties
  import ddrcap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pad_input_data,
  input wire logic sync_transfer_latch,
  input wire logic [DDRCAP_AW-1:0] reg_addr,
  input wire logic [DDRCAP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic bypass_comb_input,
  input wire logic bypass_clock_input,
  input wire logic strobe_delay_feed,
  input wire logic sdr_data_out,
  input wire ddrcap_pair_t ddr_data_out,
  input wire logic [DDRCAP_DW-1:0] reg_rdata
);
  logic [5:0] cfg_reg;
  logic [5:0] cfg_next;
  // Shadow of the configuration register
  always_comb cfg_next = (reg_wr && reg_addr == DDRCAP_CFG_OFS) ? reg_wdata[5:0] : cfg_reg;
  always_ff @(posedge clk) cfg_reg <= rst_n ? cfg_next : DDRCAP_CFG_RESET;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sdr_quiet_s;
    (cfg_reg[3:0] == 4'h0 && $stable(pad_input_data))[*7];
  endsequence
  sequence latch_low_s;
    (!sync_transfer_latch)[*8];
  endsequence
  byp_comb_a: assert property (bypass_comb_input == pad_input_data)
    else $error("comb bypass");
  byp_clock_a: assert property (bypass_clock_input == pad_input_data)
    else $error("clock bypass");
  delay_feed_a: assert property (strobe_delay_feed == (pad_input_data && cfg_reg[5]))
    else $error("strobe feed");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data idle");
  cfg_readback_a: assert property (reg_rd && reg_addr == DDRCAP_CFG_OFS
    |=> reg_rdata == {26'h0, $past(cfg_reg)}) else $error("cfg readback");
  status_pair_a: assert property (reg_rd && reg_addr == DDRCAP_STATUS_OFS
    |=> reg_rdata[1:0] == $past(ddr_data_out)) else $error("status pair");
  sdr_capture_a: assert property (sdr_quiet_s |-> sdr_data_out == pad_input_data)
    else $error("sdr capture");
  latch_hold_a: assert property (latch_low_s |-> $stable(ddr_data_out))
    else $error("latch hold");
endmodule
bind ddrcap_input_block ddrcap_properties u_ddrcap_properties (.*);
`default_nettype wire

// [tb/ddrcap_read_model.sv]
// Read strobe source and read control model
`default_nettype none
module ddrcap_read_model (
  output logic pad,
  output logic stb,
  output logic eck,
  output logic pol,
  output logic lat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {pad, stb, eck, pol} = 4'h0;
    lat = 1'h1;
  end
  task automatic hold(input logic l);
    lat <= l;
  endtask
  task automatic set_pad(input logic v);
    pad <= v;
  endtask
  // Preamble low, then bit pairs on both clock edges, each edge 38 ns into its bit
  task automatic burst(input logic g, input logic p, input logic [7:0] b);
    #7;
    pol = p;
    #200;
    for (int i = 7; i > 0; i -= 2) begin
      pad = b[i];
      #38;
      if (g) eck = 1'h1;
      else stb = 1'h1;
      #62;
      pad = b[i-1];
      #38;
      {eck, stb} = 2'h0;
      #62;
    end
    // Released line shows the inverse
    pad = ~pad;
  endtask
endmodule
`default_nettype wire

// [tb/ddrcap_input_block_bench.sv]
// Self-checking bench of the input capture block
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module ddrcap_input_block_bench
  import ddrcap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FIX = 5;
  localparam logic [7:0] CF = DDRCAP_CFG_OFS;
  localparam logic [7:0] ST = DDRCAP_STATUS_OFS;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic pend = 1'h0;
  logic [3:0] dynamic_delay_code = 4'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic pad_input_data, read_strobe_edge_clock, edge_clock, sync_clock_polarity;
  logic sync_transfer_latch, bypass_comb_input, bypass_clock_input, strobe_delay_feed;
  logic sdr_data_out, gear_neg_stream_a, gear_pos_stream_a, gear_neg_stream_b, gear_pos_stream_b;
  logic [3:0] gear;
  ddrcap_pair_t ddr_data_out;
  logic [63:0] expq[$];
  int fails = 0;
  int compares = 0;
  assign gear = {gear_neg_stream_a, gear_pos_stream_a, gear_neg_stream_b, gear_pos_stream_b};
  ddrcap_read_model u_ddrcap_read_model (.pad(pad_input_data), .stb(read_strobe_edge_clock),
    .eck(edge_clock), .pol(sync_clock_polarity), .lat(sync_transfer_latch));
  ddrcap_input_block #(.FIXED_DELAY_TAP(FIX)) u_ddrcap_input_block (.*);
  initial forever #12.5 clk = ~clk;
  initial begin
    #200us;
    fails++;
    finish_test();
  end
  // Read data stands in the cycle after the strobe
  always @(posedge clk) begin
    logic [63:0] e;
    if (pend) begin
      e = expq.pop_front();
      `CHK("reg_rdata", e[31:0], reg_rdata & e[63:32])
    end
    pend <= reg_rd;
  end
  task automatic finish_test();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    expq.push_back({m, e & m});
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic frame(input logic g, input logic p, input logic [7:0] b);
    u_ddrcap_read_model.burst(g, p, b);
    tick(14);
  endtask
  // Cycles from a pad change to the single-rate output
  task automatic lat(output int n);
    logic v;
    v = ~sdr_data_out;
    u_ddrcap_read_model.set_pad(v);
    n = 0;
    while (sdr_data_out !== v) begin
      @(posedge clk);
      n++;
      if (n > 60) begin
        fails++;
        finish_test();
      end
    end
  endtask
  initial begin
    int n;
    int l0;
    logic [7:0] b;
    void'($urandom(71));
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rreg(CF, 32'hFFFFFFFF, 32'h0);
    wreg(CF, 32'hFFFFFFFF);
    rreg(CF, 32'hFFFFFFFF, 32'h3F);
    wreg(8'h10, 32'hFFFFFFFF);
    rreg(8'h10, 32'hFFFFFFFF, 32'h0);
    wreg(ST, 32'hFFFFFFFF);
    rreg(ST, 32'h3F, 32'h0);
    for (int i = 0; i < 8; i++) begin
      b[0] = 1'($urandom);
      wreg(CF, {26'h0, i[0], 5'h0});
      u_ddrcap_read_model.set_pad(b[0]);
      tick(1);
      `CHK("comb", b[0], bypass_comb_input)
      `CHK("clock", b[0], bypass_clock_input)
      `CHK("feed", b[0] & i[0], strobe_delay_feed)
      tick(9);
      `CHK("sdr", b[0], sdr_data_out)
    end
    wreg(CF, 32'h0);
    tick(20);
    lat(l0);
    wreg(CF, 32'h4);
    tick(30);
    lat(n);
    `CHK("fixed", l0 + FIX + 1, n)
    for (int i = 0; i < 4; i++) begin
      dynamic_delay_code <= i == 0 ? 4'hF : 4'($urandom);
      wreg(CF, 32'hC);
      tick(30);
      lat(n);
      `CHK("dyn", l0 + int'(dynamic_delay_code) + 1, n)
    end
    for (int m = 1; m < 3; m++)
      for (int p = 0; p < 2; p++) begin
        b = 8'($urandom);
        wreg(CF, 32'(m));
        frame(m == 2, p[0], b);
        `CHK("pair", b[1:0], ddr_data_out)
        rreg(ST, 32'h3, {30'h0, b[1:0]});
        frame(m != 2, p[0], ~b);
        `CHK("other", b[1:0], ddr_data_out)
      end
    u_ddrcap_read_model.hold(1'h0);
    tick(8);
    frame(1'h1, 1'h0, ~b);
    `CHK("hold", b[1:0], ddr_data_out)
    u_ddrcap_read_model.hold(1'h1);
    tick(8);
    `CHK("move", ~b[1:0], ddr_data_out)
    for (int i = 0; i < 2; i++) begin
      wreg(CF, 32'h12);
      frame(1'h1, 1'h0, i ? 8'hAA : 8'h55);
      b[3:0] = i ? 4'h5 : 4'hA;
      `CHK("gear", b[3:0], gear)
      rreg(ST, 32'h3C, {26'h0, b[3:0], 2'h0});
    end
    wreg(CF, 32'h10);
    frame(1'h1, 1'h0, 8'h55);
    `CHK("gear_off", 4'h5, gear)
    finish_test();
  end
endmodule
`default_nettype wire
